// ### test/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    // Bench clock, reset and DUT ports
    logic                  clk;
    logic                  nrst;
    ofc_pkg::ofc_avm_req_t avm_req;
    logic [31:0]           avm_readdata;
    logic                  avm_waitrequest;
    ofc_pkg::ofc_events_t  port_events;
    int                    n_mismatch;
    int                    n_compared;
    int                    cyc;

    ofc_counters u_dut (
        .clk            (clk),
        .nrst           (nrst),
        .avm_req        (avm_req),
        .avm_readdata   (avm_readdata),
        .avm_waitrequest(avm_waitrequest),
        .port_events    (port_events)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // Verdict and end of run, reached from the sequence or the watchdog
    task automatic wrap_up();
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Watchdog sized for the saturation run plus margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            $display("ERROR t=%0t watchdog expired", $time);
            wrap_up();
        end
    end

    // Byte compare; readdata upper bits must stay zero
    task automatic chk(input logic [31:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== {24'h00_0000, exp}) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon transfer; request held until waitrequest sampled low
    task automatic xfer(input logic wr, input logic [7:0] a,
                        output logic [31:0] d);
        avm_req.address   <= a;
        avm_req.read      <= ~wr;
        avm_req.write     <= wr;
        avm_req.writedata <= 32'h0000_00a5;
        avm_req.byteenable <= 4'hf;
        @(posedge clk);
        while (avm_waitrequest !== 1'b0) @(posedge clk);
        d = avm_readdata;
        avm_req.read  <= 1'b0;
        avm_req.write <= 1'b0;
        // Let the release land before any new request
        @(posedge clk);
    endtask : xfer

    // Read a register and compare its byte
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] d;
        xfer(1'b0, a, d);
        chk(d, exp);
    endtask : rdc

    // Back-to-back event pulses, one per cycle
    task automatic ev(input logic [3:0] e, input int n);
        repeat (n) begin
            port_events <= ofc_pkg::ofc_events_t'(e);
            @(posedge clk);
        end
        port_events <= ofc_pkg::ofc_events_t'(4'h0);
        @(posedge clk);
    endtask : ev

    // Main sequence
    initial begin
        logic [31:0] d;
        clk = 1'b0;
        nrst = 1'b0;
        avm_req = '0;
        port_events = ofc_pkg::ofc_events_t'(4'h0);
        n_mismatch = 0;
        n_compared = 0;
        cyc = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset values of all eight registers
        for (int i = 0; i < 8; i++) rdc(8'h98 + 8'(i), 8'h00);
        // Frames 300, errored frames 3, lines 604, errored lines 7
        ev(4'hf, 3);
        ev(4'ha, 297);
        ev(4'h2, 300);
        ev(4'h3, 4);
        ev(4'h4, 1);
        ev(4'h1, 1);
        // Lower before upper still shows the old snapshot
        rdc(8'h99, 8'h00);
        rdc(8'h9d, 8'h00);
        // A write is acknowledged but must not clear anything
        xfer(1'b1, 8'h98, d);
        rdc(8'h98, 8'h01);
        rdc(8'h99, 8'h2c);
        rdc(8'h99, 8'h2c);
        rdc(8'h9a, 8'h00);
        rdc(8'h9b, 8'h03);
        rdc(8'h9c, 8'h02);
        rdc(8'h9d, 8'h5c);
        rdc(8'h9d, 8'h5c);
        rdc(8'h9e, 8'h00);
        rdc(8'h9f, 8'h07);
        rdc(8'h9f, 8'h07);
        // Counters were cleared by their upper reads
        rdc(8'h98, 8'h00);
        rdc(8'h99, 8'h00);
        rdc(8'h9a, 8'h00);
        rdc(8'h9b, 8'h00);
        rdc(8'h9c, 8'h00);
        rdc(8'h9e, 8'h00);
        // Unmapped addresses read zero
        rdc(8'h97, 8'h00);
        rdc(8'ha0, 8'h00);
        // Two events past full scale must stick at full scale
        ev(4'h3, 65537);
        rdc(8'h9c, 8'hff);
        rdc(8'h9d, 8'hff);
        rdc(8'h9e, 8'hff);
        rdc(8'h9f, 8'hff);
        rdc(8'h98, 8'h00);
        wrap_up();
    end
endmodule : tb

`default_nettype wire

// ### verilog/ofc_counters.sv
`timescale 1ns/10ps
`default_nettype none
`include "ofc_params.svh"

//
// Contract
// - A frame-total lower read returns the low byte held by the last upper read and leaves the counter alone.
// - A frame-total upper read returns bits 15:8, holds bits 7:0 for the lower register and clears the counter.
// - An errored-frame upper read returns bits 15:8, holds the low byte and clears the counter.
// - The errored-frame lower register returns the held low byte; software reads the upper byte first.
// - A line-total upper read returns bits 15:8, holds bits 7:0 and clears the counter.
// - The line-total lower register returns the held low byte with no side effect; upper is read first.
// - An errored-line upper read returns bits 15:8, holds the low byte and clears the counter.
// - The errored-line lower register returns the held low byte with no side effect; upper first.
module ofc_counters (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Avalon-MM slave
    input  wire ofc_pkg::ofc_avm_req_t avm_req,
    output var  logic [31:0]          avm_readdata,
    output var  logic                 avm_waitrequest,
    // Output port 1 events
    input  wire ofc_pkg::ofc_events_t  port_events
);

    // Four 16-bit counters and their low-byte holding registers
    logic [15:0] count_reg [4];
    logic [7:0]  hold_reg  [4];
    ofc_pkg::ofc_state_t state_reg;
    logic [2:0]  dec;
    logic [1:0]  sel;
    logic        is_upper;
    logic        hit;
    logic        clr_pulse;
    logic [3:0]  step;
    logic [31:0] rdata_next;

    // Saturating increment used by all four counters
    function automatic logic [15:0] ofc_sat_inc(input logic [15:0] v);
        if (v == `OFC_COUNT_MAX) begin
            return v;
        end
        return v + 16'h0001;
    endfunction : ofc_sat_inc

    // Address decode: index 0x98..0x9f, even is upper, odd is lower
    function automatic logic [2:0] ofc_decode(input logic [7:0] idx);
        logic [7:0] rel;
        rel = idx - `OFC_FRAMES_UPPER_IDX;
        return rel[2:0];
    endfunction : ofc_decode

    // Byte address carries the index in bits 9:2; the word address is the index itself
    // A function result cannot be sliced directly, so it lands in dec first
    always_comb begin
        dec      = ofc_decode(avm_req.address);
        hit      = (avm_req.address >= `OFC_FRAMES_UPPER_IDX)
                && (avm_req.address <= `OFC_ERR_LINES_LOWER_IDX);
        sel      = dec[2:1];
        is_upper = ~dec[0];
    end

    // Event steps in counter order frames, err frames, lines, err lines
    // event counting
    always_comb begin
        step[ofc_pkg::OFC_SEL_FRAMES]     = port_events.frame_done;
        step[ofc_pkg::OFC_SEL_ERR_FRAMES] = port_events.frame_done
                                          & port_events.frame_err;
        step[ofc_pkg::OFC_SEL_LINES]      = port_events.line_done;
        step[ofc_pkg::OFC_SEL_ERR_LINES]  = port_events.line_done
                                          & port_events.line_err;
    end

    // One read is acted on once, in the cycle the answer is prepared
    assign clr_pulse = (state_reg == ofc_pkg::OFC_ST_IDLE) & avm_req.read
                     & hit & is_upper;

    // Bus handshake: one wait cycle, then answer, then a recovery cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ofc_pkg::OFC_ST_IDLE;
        end else begin
            unique case (state_reg)
                ofc_pkg::OFC_ST_IDLE: begin
                    if (avm_req.read || avm_req.write) begin
                        state_reg <= ofc_pkg::OFC_ST_ACK;
                    end
                end
                ofc_pkg::OFC_ST_ACK: begin
                    state_reg <= ofc_pkg::OFC_ST_DONE;
                end
                ofc_pkg::OFC_ST_DONE: begin
                    state_reg <= ofc_pkg::OFC_ST_IDLE;
                end
            endcase
        end
    end

    // Waitrequest is low only in the answer cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avm_waitrequest <= 1'b1;
        end else begin
            avm_waitrequest <= ~((state_reg == ofc_pkg::OFC_ST_IDLE)
                                & (avm_req.read | avm_req.write));
        end
    end

    // Read data mux; writes are accepted and ignored since all are RO
    // lower from hold
    always_comb begin
        rdata_next = `OFC_UNMAPPED_DATA;
        if (hit) begin
            if (is_upper) begin
                rdata_next[7:0] =
                    count_reg[sel][`OFC_UPPER_MSB:`OFC_UPPER_LSB];
            end else begin
                rdata_next[7:0] = hold_reg[sel];
            end
        end
    end

    // Read data is registered with the answer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avm_readdata <= `OFC_UNMAPPED_DATA;
        end else if (state_reg == ofc_pkg::OFC_ST_IDLE && avm_req.read) begin
            avm_readdata <= rdata_next;
        end
    end

    // Counters: a clearing read wins, but an event in that same cycle
    // restarts the count at one so no event is lost.
    // upper read clears
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                count_reg[i] <= `OFC_COUNT_RESET;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (clr_pulse && sel == i[1:0]) begin
                    count_reg[i] <= {15'h0000, step[i]};
                end else if (step[i]) begin
                    count_reg[i] <= ofc_sat_inc(count_reg[i]);
                end
            end
        end
    end

    // Snapshot of the low byte taken by the clearing upper read
    // low byte snapshot
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++) begin
                hold_reg[i] <= `OFC_HOLD_RESET;
            end
        end else if (clr_pulse) begin
            hold_reg[sel] <= count_reg[sel][`OFC_LOWER_MSB:`OFC_LOWER_LSB];
        end
    end

    upper_clears_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse && !step[sel] |=> count_reg[$past(sel)] == 16'h0000)
        else $error("counter not cleared by upper read");

    hold_stable_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !clr_pulse |=> $stable(hold_reg[0]))
        else $error("frame hold changed without upper read");

    upper_data_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse |=> avm_readdata[7:0] == $past(count_reg[sel][15:8]))
        else $error("upper read returned wrong byte");

    lower_data_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == ofc_pkg::OFC_ST_IDLE && avm_req.read && hit
        && !is_upper |=> avm_readdata[7:0] == $past(hold_reg[sel]))
        else $error("lower read returned wrong byte");

    hold_capture_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse |=> hold_reg[$past(sel)] == $past(count_reg[sel][7:0]))
        else $error("low byte not captured");

    lower_no_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !clr_pulse && !step[2] |=> $stable(count_reg[2]))
        else $error("line counter changed without cause");

    wait_bound_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == ofc_pkg::OFC_ST_IDLE && avm_req.read
        |=> !avm_waitrequest ##1 avm_waitrequest)
        else $error("answer not one cycle after request");

    err_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !clr_pulse |=> $stable(hold_reg[3]))
        else $error("errored line hold changed");

    saturate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        count_reg[0] == `OFC_COUNT_MAX && !clr_pulse
        |=> count_reg[0] == `OFC_COUNT_MAX)
        else $error("frame counter wrapped");

    err_only_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !port_events.frame_err && !clr_pulse |=> $stable(count_reg[1]))
        else $error("errored frame counted without error");

    err_frame_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse && sel == 2'h1 && !step[1]
        |=> count_reg[1] == `OFC_COUNT_RESET)
        else $error("errored frame counter not cleared");

    line_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse && sel == 2'h2 && !step[2]
        |=> count_reg[2] == `OFC_COUNT_RESET)
        else $error("line counter not cleared");

    err_line_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse && sel == 2'h3 && !step[3]
        |=> count_reg[3] == `OFC_COUNT_RESET)
        else $error("errored line counter not cleared");

    err_line_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse && sel == 2'h3
        |=> hold_reg[3] == $past(count_reg[3][7:0]))
        else $error("errored line low byte not captured");

    err_frame_hold_a: assert property (
        @(posedge clk) disable iff (!nrst)
        clr_pulse && sel == 2'h1
        |=> hold_reg[1] == $past(count_reg[1][7:0]))
        else $error("errored frame low byte not captured");

    err_frame_keep_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !(clr_pulse && sel == 2'h1) |=> $stable(hold_reg[1]))
        else $error("errored frame hold changed");

    line_hold_keep_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !(clr_pulse && sel == 2'h2) |=> $stable(hold_reg[2]))
        else $error("line hold changed");

    frame_keep_a: assert property (
        @(posedge clk) disable iff (!nrst)
        avm_req.read && hit && !is_upper && !step[0]
        |=> $stable(count_reg[0]))
        else $error("frame counter changed by lower read");

    err_line_keep_a: assert property (
        @(posedge clk) disable iff (!nrst)
        avm_req.read && hit && !is_upper && !step[3]
        |=> $stable(count_reg[3]))
        else $error("errored line counter changed by lower read");

    err_line_only_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !port_events.line_err && !clr_pulse |=> $stable(count_reg[3]))
        else $error("errored line counted without error");

    line_saturate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        count_reg[2] == `OFC_COUNT_MAX && !(clr_pulse && sel == 2'h2)
        |=> count_reg[2] == `OFC_COUNT_MAX)
        else $error("line counter wrapped");

    err_line_sat_a: assert property (
        @(posedge clk) disable iff (!nrst)
        count_reg[3] == `OFC_COUNT_MAX && !(clr_pulse && sel == 2'h3)
        |=> count_reg[3] == `OFC_COUNT_MAX)
        else $error("errored line counter wrapped");

    write_ignored_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == ofc_pkg::OFC_ST_IDLE && avm_req.write && !step[0]
        |=> $stable(count_reg[0]))
        else $error("write disturbed frame counter");

    data_width_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !avm_waitrequest |-> avm_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");

    unmapped_a: assert property (
        @(posedge clk) disable iff (!nrst)
        state_reg == ofc_pkg::OFC_ST_IDLE && avm_req.read && !hit
        |=> avm_readdata == `OFC_UNMAPPED_DATA)
        else $error("unmapped read not zero");

    // Main scenarios: clearing read, lower read, clash, saturation, write
    write_c: cover property (@(posedge clk)
        avm_req.write && !avm_waitrequest);
    upper_read_c: cover property (@(posedge clk) clr_pulse);
    lower_read_c: cover property (@(posedge clk)
        avm_req.read && hit && !is_upper && !avm_waitrequest);
    clear_event_c: cover property (@(posedge clk) clr_pulse && step[sel]);
    saturated_c: cover property (@(posedge clk) count_reg[2] == 16'hffff);

endmodule : ofc_counters

`default_nettype wire

// ### verilog/ofc_params.svh
`ifndef OFC_PARAMS_SVH
`define OFC_PARAMS_SVH

// Register index (printed offset); byte address is four times the index
`define OFC_FRAMES_UPPER_IDX        8'h98
`define OFC_FRAMES_LOWER_IDX        8'h99
`define OFC_ERR_FRAMES_UPPER_IDX    8'h9a
`define OFC_ERR_FRAMES_LOWER_IDX    8'h9b
`define OFC_LINES_UPPER_IDX         8'h9c
`define OFC_LINES_LOWER_IDX         8'h9d
`define OFC_ERR_LINES_UPPER_IDX     8'h9e
`define OFC_ERR_LINES_LOWER_IDX     8'h9f

// Field positions inside a 16-bit counter
`define OFC_UPPER_MSB               15
`define OFC_UPPER_LSB               8
`define OFC_LOWER_MSB               7
`define OFC_LOWER_LSB               0

// Reset values
`define OFC_COUNT_RESET             16'h0000
`define OFC_HOLD_RESET              8'h00

// Full-scale count at which counters stop
`define OFC_COUNT_MAX               16'hffff

// Read data on an unmapped address
`define OFC_UNMAPPED_DATA           32'h0000_0000

`endif

// ### verilog/ofc_pkg.sv
package ofc_pkg;

    // Counter selector
    typedef enum logic [1:0] {
        OFC_SEL_FRAMES     = 2'h0,
        OFC_SEL_ERR_FRAMES = 2'h1,
        OFC_SEL_LINES      = 2'h2,
        OFC_SEL_ERR_LINES  = 2'h3
    } ofc_sel_t;

    // Events reported by the output port logic
    typedef struct packed {
        logic frame_done;
        logic frame_err;
        logic line_done;
        logic line_err;
    } ofc_events_t;

    // Avalon-MM request from the master
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } ofc_avm_req_t;

    // Bus state machine
    typedef enum logic [2:0] {
        OFC_ST_IDLE = 3'b001,
        OFC_ST_ACK  = 3'b010,
        OFC_ST_DONE = 3'b100
    } ofc_state_t;

endpackage : ofc_pkg
